// ---- logic/sri_pkg.sv ----
// Constants and types shared by the serial-unit reset and initialization control
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package sri_pkg;
	// Bus shape
	localparam int          ADDR_W    = 16;
	localparam int          DATA_W    = 24;
	// Register addresses in the data memory space
	localparam logic [15:0] ADDR_PFC  = 16'hffe0;
	localparam logic [15:0] ADDR_IFC  = 16'hfff0;
	localparam logic [15:0] ADDR_STAT = 16'hfff1;
	localparam logic [15:0] ADDR_CLK  = 16'hfff2;
	localparam logic [15:0] ADDR_TXA  = 16'hfff3;
	localparam logic [15:0] ADDR_DLO  = 16'hfff4;
	localparam logic [15:0] ADDR_DMID = 16'hfff5;
	localparam logic [15:0] ADDR_DHI  = 16'hfff6;
	// Byte lane codes for the packed data addresses
	localparam logic [1:0]  LANE_LO   = 2'h0;
	localparam logic [1:0]  LANE_MID  = 2'h1;
	localparam logic [1:0]  LANE_HI   = 2'h2;
	localparam logic [1:0]  LANE_NONE = 2'h3;
	// Status bit positions
	localparam int          ST_NINTH  = 7;
	localparam int          ST_FRAME  = 6;
	localparam int          ST_PARITY = 5;
	localparam int          ST_OR     = 4;
	localparam int          ST_IDLE   = 3;
	localparam int          ST_RXFULL = 2;
	localparam int          ST_TXHE   = 1;
	localparam int          ST_TXSE   = 0;
	// Receive error index inside the error vector
	localparam int          ERR_OR    = 0;
	localparam int          ERR_PAR   = 1;
	localparam int          ERR_FRM   = 2;
	// Reset values
	localparam logic [7:0]  STAT_RST  = 8'h03;
	localparam logic [15:0] IFC_RST   = 16'h0000;
	localparam logic [15:0] CLK_RST   = 16'h0000;
	localparam logic [2:0]  PFC_RST   = 3'h0;
	// Unit operating state
	typedef enum logic [1:0] {
		UNIT_RESET = 2'b00,
		UNIT_WAIT  = 2'b01,
		UNIT_RUN   = 2'b10
	} sri_unit_t;
endpackage

// ---- logic/sri_flag_if.sv ----
// Carrier between the control block and the status flag block
interface sri_flag_if;
	logic       ce;
	logic       flag_rst;
	logic       rx_load;
	logic [2:0] rx_err;
	logic       rx_bit9;
	logic       idle_set;
	logic       rx_read;
	logic       tx_write;
	logic       tx_xfer;
	logic       tx_done;
	logic [7:0] status;
	modport ctrl  (output ce, flag_rst, rx_load, rx_err, rx_bit9, idle_set, rx_read,
		tx_write, tx_xfer, tx_done, input status);
	modport flags (input ce, flag_rst, rx_load, rx_err, rx_bit9, idle_set, rx_read,
		tx_write, tx_xfer, tx_done, output status);
endinterface

// ---- logic/sri_status.sv ----
// Status flag register of the serial unit
module sri_status
	import sri_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Flag events and status read-back
	sri_flag_if.flags fl
);
	wire  [2:0] err_w;
	logic       ninth_r;
	logic       idle_r;
	logic       rxfull_r;
	logic       txhe_r;
	logic       txse_r;

	// Receive error flags share one shape; a new error beats a same-cycle read clear
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_err
			logic err_r;
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					err_r <= 1'b0;
				end else if (fl.ce) begin
					if (fl.flag_rst) begin
						err_r <= 1'b0;
					end else if (fl.rx_load && fl.rx_err[g]) begin
						err_r <= 1'b1;
					end else if (fl.rx_read) begin
						err_r <= 1'b0;
					end
				end
			end
			assign err_w[g] = err_r;
		end
	endgenerate

	// Receive side flags; captured ninth bit follows each loaded word
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ninth_r  <= 1'b0;
			idle_r   <= 1'b0;
			rxfull_r <= 1'b0;
		end else if (fl.ce) begin
			if (fl.flag_rst) begin
				ninth_r  <= 1'b0;
				idle_r   <= 1'b0;
				rxfull_r <= 1'b0;
			end else begin
				if (fl.rx_load) begin
					ninth_r <= fl.rx_bit9;
				end
				if (fl.idle_set) begin
					idle_r <= 1'b1;
				end else if (fl.rx_read) begin
					idle_r <= 1'b0;
				end
				if (fl.rx_load) begin
					rxfull_r <= 1'b1;
				end else if (fl.rx_read) begin
					rxfull_r <= 1'b0;
				end
			end
		end
	end

	// Transmit side flags come up set: nothing is waiting after any reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			txhe_r <= 1'b1;
			txse_r <= 1'b1;
		end else if (fl.ce) begin
			if (fl.flag_rst) begin
				txhe_r <= 1'b1;
				txse_r <= 1'b1;
			end else begin
				if (fl.tx_xfer) begin
					txhe_r <= 1'b1;
				end else if (fl.tx_write) begin
					txhe_r <= 1'b0;
				end
				if (fl.tx_done) begin
					txse_r <= 1'b1;
				end else if (fl.tx_xfer) begin
					txse_r <= 1'b0;
				end
			end
		end
	end

	// Status word assembly
	always_comb begin
		fl.status            = 8'h00;
		fl.status[ST_NINTH]  = ninth_r;
		fl.status[ST_FRAME]  = err_w[ERR_FRM];
		fl.status[ST_PARITY] = err_w[ERR_PAR];
		fl.status[ST_OR]     = err_w[ERR_OR];
		fl.status[ST_IDLE]   = idle_r;
		fl.status[ST_RXFULL] = rxfull_r;
		fl.status[ST_TXHE]   = txhe_r;
		fl.status[ST_TXSE]   = txse_r;
	end

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	property p_flag_rst_val;
		@(posedge ref_clk) disable iff (!rst_b)
		(fl.ce && fl.flag_rst) |=> (fl.status == STAT_RST);
	endproperty
	a_flag_rst_val: assert property (p_flag_rst_val) else $error("status not at reset value");

	property p_set_wins;
		@(posedge ref_clk) disable iff (!rst_b)
		(fl.ce && !fl.flag_rst && fl.rx_load && fl.rx_read) |=> fl.status[ST_RXFULL];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("receive full lost to read");

	// A transfer in the cycle after the write must bring holding empty back
	property p_txhe_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		(fl.ce && !fl.flag_rst && fl.tx_write && !fl.tx_xfer)
			|=> !fl.status[ST_TXHE]
			##1 (fl.status[ST_TXHE] || !$past(fl.ce && fl.tx_xfer));
	endproperty
	a_txhe_clear: assert property (p_txhe_clear) else $error("holding empty not cleared");

	property p_parity_set;
		@(posedge ref_clk) disable iff (!rst_b)
		(fl.ce && !fl.flag_rst && fl.rx_load && fl.rx_err[ERR_PAR])
			|=> fl.status[ST_PARITY] && fl.status[ST_RXFULL];
	endproperty
	a_parity_set: assert property (p_parity_set) else $error("parity flag not set");
endmodule

// ---- logic/sri_ctrl.sv ----
// Reset, initialization and register control of the serial unit
module sri_ctrl
	import sri_pkg::*;
(
	// Clock, reset and clock enable
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic              clk_en,
	// Core requests
	input  wire logic              sw_reset,
	input  wire logic              stop_mode,
	input  wire logic              int_used,
	input  wire logic              int_enabled,
	input  wire logic              int_unmasked,
	// Data memory space access
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic              bus_rd,
	input  wire logic              bus_wr,
	input  wire logic [DATA_W-1:0] bus_wdata,
	output logic      [DATA_W-1:0] bus_rdata,
	// Receive datapath
	input  wire logic              rx_load,
	input  wire logic [7:0]        rx_byte,
	input  wire logic              rx_ninth,
	input  wire logic [2:0]        rx_err,
	input  wire logic              idle_det,
	// Transmit datapath
	input  wire logic              tx_xfer,
	input  wire logic              tx_done,
	output logic      [7:0]        tx_byte,
	output logic                   tx_ninth,
	output logic                   tx_holding_empty,
	// Unit control outputs
	output logic                   unit_hold,
	output logic                   unit_run,
	output logic      [15:0]       interface_control,
	output logic      [15:0]       bit_clock_control,
	output logic      [2:0]        pin_func
);
	sri_flag_if fl ();

	sri_unit_t         state_r;
	sri_unit_t         state_nxt;
	logic [15:0]       ifc_r;
	logic [15:0]       clk_r;
	logic [2:0]        pfc_r;
	logic [2:0]        pfc_nxt;
	logic [7:0]        rxh_r;
	logic [7:0]        txh_r;
	logic              txa_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              held;
	logic              armed;
	logic              wr_ifc;
	logic              wr_clk;
	logic              wr_pfc;
	logic              wr_tx;

	// -------------------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------------------

	// Byte lane of a packed data address; both read and write paths use it
	function automatic logic [1:0] data_lane(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_DLO:  data_lane = LANE_LO;
			ADDR_DMID: data_lane = LANE_MID;
			ADDR_DHI:  data_lane = LANE_HI;
			default:   data_lane = LANE_NONE;
		endcase
	endfunction

	// Write strobes, all qualified by the clock enable
	assign wr_ifc = clk_en && bus_wr && (bus_addr == ADDR_IFC);
	assign wr_clk = clk_en && bus_wr && (bus_addr == ADDR_CLK);
	assign wr_pfc = clk_en && bus_wr && (bus_addr == ADDR_PFC);
	assign wr_tx  = clk_en && bus_wr && !held &&
		((bus_addr == ADDR_TXA) || (data_lane(bus_addr) != LANE_NONE));

	// -------------------------------------------------------------------------
	// Reset sources and unit state
	// -------------------------------------------------------------------------

	// Next pin-function selects; software reset beats a same-cycle write
	always_comb begin
		pfc_nxt = pfc_r;
		if (sw_reset) begin
			pfc_nxt = PFC_RST;
		end else if (bus_wr && (bus_addr == ADDR_PFC)) begin
			pfc_nxt = bus_wdata[2:0];
		end
	end

	// Hold is derived from next values so entry and release land on one edge
	assign held  = sw_reset || stop_mode || (pfc_nxt == PFC_RST);
	assign armed = !int_used || (int_enabled && int_unmasked);

	// Unit state: when int_used is set, whichever of pins, enable or unmask comes last starts it
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			UNIT_RESET: begin
				if (!held) begin
					state_nxt = armed ? UNIT_RUN : UNIT_WAIT;
				end
			end
			UNIT_WAIT: begin
				if (held) begin
					state_nxt = UNIT_RESET;
				end else if (armed) begin
					state_nxt = UNIT_RUN;
				end
			end
			UNIT_RUN: begin
				if (held) begin
					state_nxt = UNIT_RESET;
				end else if (!armed) begin
					state_nxt = UNIT_WAIT;
				end
			end
			default: state_nxt = UNIT_RESET;
		endcase
	end

	// Registered state keeps hold and run free of decode glitches
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= UNIT_RESET;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	assign unit_hold = (state_r == UNIT_RESET);
	assign unit_run  = (state_r == UNIT_RUN);

	// -------------------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------------------

	// Interface and clock control: only hardware or software reset clears them
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ifc_r <= IFC_RST;
			clk_r <= CLK_RST;
		end else if (clk_en) begin
			if (sw_reset) begin
				ifc_r <= IFC_RST;
				clk_r <= CLK_RST;
			end else begin
				if (wr_ifc) begin
					ifc_r <= bus_wdata[15:0];
				end
				if (wr_clk) begin
					clk_r <= bus_wdata[15:0];
				end
			end
		end
	end

	// Pin-function selects; zero hands every pin back to general-purpose I/O
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pfc_r <= PFC_RST;
		end else if (clk_en) begin
			pfc_r <= pfc_nxt;
		end
	end

	assign interface_control = ifc_r;
	assign bit_clock_control = clk_r;
	assign pin_func          = pfc_r;

	// -------------------------------------------------------------------------
	// Data holding registers
	// -------------------------------------------------------------------------

	// No reset here on purpose: contents survive every reset type
	always_ff @(posedge ref_clk) begin
		if (clk_en && rx_load && !unit_hold) begin
			rxh_r <= rx_byte;
		end
	end

	// Transmit holding: the ninth-bit address is set only by the ADDR_TXA write
	always_ff @(posedge ref_clk) begin
		if (wr_tx) begin
			if (bus_addr == ADDR_TXA) begin
				txh_r <= bus_wdata[7:0];
				txa_r <= 1'b1;
			end else begin
				txh_r <= bus_wdata[{data_lane(bus_addr), 3'b000} +: 8];
				txa_r <= 1'b0;
			end
		end
	end

	assign tx_byte          = txh_r;
	assign tx_ninth         = txa_r;
	assign tx_holding_empty = fl.status[ST_TXHE];

	// -------------------------------------------------------------------------
	// Register read path
	// -------------------------------------------------------------------------

	// Read mux; write-only and unmapped addresses return zero
	always_comb begin
		rdata_nxt = '0;
		case (bus_addr)
			ADDR_IFC:  rdata_nxt[15:0] = ifc_r;
			ADDR_STAT: rdata_nxt[7:0]  = fl.status;
			ADDR_CLK:  rdata_nxt[15:0] = clk_r;
			ADDR_PFC:  rdata_nxt[2:0]  = pfc_r;
			default: begin
				if (data_lane(bus_addr) != LANE_NONE) begin
					rdata_nxt[{data_lane(bus_addr), 3'b000} +: 8] = rxh_r;
				end
			end
		endcase
	end

	// Read data is held until the next read
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= '0;
		end else if (clk_en && bus_rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign bus_rdata = rdata_r;

	// -------------------------------------------------------------------------
	// Status flag block
	// -------------------------------------------------------------------------

	// Datapath events are dropped while held so the engines stay idle
	assign fl.ce       = clk_en;
	assign fl.flag_rst = held;
	assign fl.rx_load  = rx_load && !unit_hold;
	assign fl.rx_err   = rx_err;
	assign fl.rx_bit9  = rx_ninth;
	assign fl.idle_set = idle_det && !unit_hold;
	assign fl.rx_read  = bus_rd && (data_lane(bus_addr) != LANE_NONE);
	assign fl.tx_write = bus_wr &&
		((bus_addr == ADDR_TXA) || (data_lane(bus_addr) != LANE_NONE));
	assign fl.tx_xfer  = tx_xfer && !unit_hold;
	assign fl.tx_done  = tx_done && !unit_hold;

	sri_status u_status (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.fl      (fl.flags)
	);

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	property p_pins_zero_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		(pfc_r == PFC_RST) |-> unit_hold;
	endproperty
	a_pins_zero_hold: assert property (p_pins_zero_hold) else $error("unit runs with no pins");

	property p_release;
		@(posedge ref_clk) disable iff (!rst_b)
		(clk_en && unit_hold && !held && armed) |=> unit_run;
	endproperty
	a_release: assert property (p_release) else $error("hold not released in one edge");

	property p_sw_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		(clk_en && sw_reset)
			|=> (ifc_r == IFC_RST) && (clk_r == CLK_RST) && (pfc_r == PFC_RST) && unit_hold;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("software reset left control set");

	property p_ir_keep;
		@(posedge ref_clk) disable iff (!rst_b)
		(clk_en && !sw_reset && !wr_ifc && wr_pfc && (bus_wdata[2:0] == PFC_RST))
			|=> unit_hold && (ifc_r == $past(ifc_r)) && (fl.status == STAT_RST);
	endproperty
	a_ir_keep: assert property (p_ir_keep) else $error("individual reset touched control");

	property p_wait_masked;
		@(posedge ref_clk) disable iff (!rst_b)
		(clk_en && int_used && !int_unmasked) |=> !unit_run;
	endproperty
	a_wait_masked: assert property (p_wait_masked) else $error("unit ran while masked");

	property p_stop;
		@(posedge ref_clk) disable iff (!rst_b)
		(clk_en && stop_mode && !sw_reset && !wr_clk)
			|=> unit_hold && (fl.status == STAT_RST) && (clk_r == $past(clk_r));
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt and reset status");

	c_release: cover property (@(posedge ref_clk) disable iff (!rst_b)
		unit_hold ##1 unit_run);
	c_late_unmask: cover property (@(posedge ref_clk) disable iff (!rst_b)
		(state_r == UNIT_WAIT) ##1 unit_run);
	c_ir: cover property (@(posedge ref_clk) disable iff (!rst_b)
		unit_run ##1 (unit_hold && (ifc_r != IFC_RST)));
	c_stop: cover property (@(posedge ref_clk) disable iff (!rst_b)
		unit_run && stop_mode ##1 unit_hold);
endmodule

// ---- tb/sri_peer.sv ----
// Far-side datapath model: receive word source and transmit shifter
module sri_peer
	import sri_pkg::*;
#(
	parameter int XFER_DLY = 6
)(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Unit state from the control block
	input  wire logic unit_hold,
	input  wire logic tx_holding_empty,
	// Receive events
	output logic      rx_load,
	output logic [7:0] rx_byte,
	output logic      rx_ninth,
	output logic [2:0] rx_err,
	output logic      idle_det,
	// Transmit events
	output logic      tx_xfer,
	output logic      tx_done
);
	timeunit 1ns;
	timeprecision 1ps;

	int hold_cnt;
	int shift_cnt;

	// ---------------------------------------------------------------
	// Receive side
	// ---------------------------------------------------------------
	// Lines idle low; data lines carry junk outside a load pulse
	initial begin
		rx_load  = 1'b0;
		idle_det = 1'b0;
		rx_byte  = 8'h00;
		rx_ninth = 1'b1;
		rx_err   = 3'h7;
	end

	// One received word, optionally with an idle-line pulse beside it
	task automatic rx_word(input logic [7:0] b, input logic [2:0] e, input logic idl);
		@(negedge ref_clk);
		rx_load  <= 1'b1;
		idle_det <= idl;
		rx_byte  <= b;
		rx_err   <= e;
		rx_ninth <= 1'b0;
		@(negedge ref_clk);
		rx_load  <= 1'b0;
		idle_det <= 1'b0;
		rx_byte  <= ~b;
		rx_err   <= ~e;
		rx_ninth <= 1'b1;
	endtask

	// ---------------------------------------------------------------
	// Transmit side
	// ---------------------------------------------------------------
	// Pull the holding byte after a delay, then finish the shift later;
	// the delay keeps the holding-empty flag low long enough to be read
	always @(negedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt  = 0;
			shift_cnt = 0;
			tx_xfer   <= 1'b0;
			tx_done   <= 1'b0;
		end else begin
			tx_xfer <= 1'b0;
			tx_done <= 1'b0;
			hold_cnt = (tx_holding_empty || unit_hold) ? 0 : hold_cnt + 1;
			if (hold_cnt >= XFER_DLY && shift_cnt == 0) begin
				tx_xfer   <= 1'b1;
				shift_cnt = 1;
			end else if (shift_cnt != 0) begin
				shift_cnt++;
				if (shift_cnt > XFER_DLY) begin
					tx_done   <= 1'b1;
					shift_cnt = 0;
				end
			end
		end
	end
endmodule

// ---- tb/sri_ctrl_tb.sv ----
// Self-checking bench for the serial-unit reset and initialization control
module sri_ctrl_tb
	import sri_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [15:0] wa;
		logic [23:0] wd;
		logic [15:0] ra;
		logic [23:0] exp;
	} sri_row_t;

	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        clk_en = 1'b1;
	logic        sw_reset = 1'b0;
	logic        stop_mode = 1'b0;
	logic        int_used = 1'b0;
	logic        int_enabled = 1'b0;
	logic        int_unmasked = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic        bus_rd = 1'b0;
	logic        bus_wr = 1'b0;
	logic [23:0] bus_wdata = 24'h000000;
	logic [23:0] bus_rdata;
	logic        rx_load, rx_ninth, idle_det, tx_xfer, tx_done, tx_ninth;
	logic [7:0]  rx_byte, tx_byte;
	logic [2:0]  rx_err, pin_func;
	logic        tx_holding_empty, unit_hold, unit_run;
	logic [15:0] interface_control, bit_clock_control;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cycles = 0;
	logic [23:0] st_base;

	// Writes go to a held unit; read-only and unmapped places must not move
	sri_row_t rows [5] = '{
		'{ADDR_IFC, 24'h00a5c3, ADDR_IFC, 24'h00a5c3},
		'{ADDR_CLK, 24'h000fff, ADDR_CLK, 24'h000fff},
		'{ADDR_STAT, 24'hffffff, ADDR_STAT, 24'h000003},
		'{16'hfff7, 24'hffffff, 16'hfff7, 24'h000000},
		'{ADDR_DLO, 24'h000077, ADDR_STAT, 24'h000003}
	};

	// ---------------------------------------------------------------
	// Design, far side and clock
	// ---------------------------------------------------------------
	sri_ctrl u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .sw_reset(sw_reset),
		.stop_mode(stop_mode), .int_used(int_used), .int_enabled(int_enabled),
		.int_unmasked(int_unmasked), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .rx_load(rx_load), .rx_byte(rx_byte),
		.rx_ninth(rx_ninth), .rx_err(rx_err), .idle_det(idle_det), .tx_xfer(tx_xfer),
		.tx_done(tx_done), .tx_byte(tx_byte), .tx_ninth(tx_ninth),
		.tx_holding_empty(tx_holding_empty), .unit_hold(unit_hold), .unit_run(unit_run),
		.interface_control(interface_control), .bit_clock_control(bit_clock_control),
		.pin_func(pin_func));

	sri_peer u_peer (.ref_clk(ref_clk), .rst_b(rst_b), .unit_hold(unit_hold),
		.tx_holding_empty(tx_holding_empty), .rx_load(rx_load), .rx_byte(rx_byte),
		.rx_ninth(rx_ninth), .rx_err(rx_err), .idle_det(idle_det), .tx_xfer(tx_xfer),
		.tx_done(tx_done));

	// 200 MHz core clock
	always #2.5 ref_clk = ~ref_clk;

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [23:0] d);
		@(negedge ref_clk);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(negedge ref_clk);
		bus_wr    <= 1'b0;
		bus_wdata <= ~d;
	endtask

	// Read data is registered, so it is settled at the following falling edge
	task automatic rd_chk(input logic [15:0] a, input logic [23:0] e);
		@(negedge ref_clk);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(negedge ref_clk);
		bus_rd <= 1'b0;
		check(bus_rdata, e);
	endtask

	task automatic hw_reset();
		@(negedge ref_clk);
		rst_b <= 1'b0;
		repeat (16) @(negedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
	endtask

	task automatic chk_cleared();
		check(24'(unit_hold), 24'h1);
		check(24'(unit_run), 24'h0);
		check(24'(pin_func), 24'(PFC_RST));
		check(24'(interface_control), 24'(IFC_RST));
		check(24'(bit_clock_control), 24'(CLK_RST));
		rd_chk(ADDR_STAT, st_base);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		st_base = 24'(STAT_RST);
		hw_reset();
		chk_cleared();
		// Control setup while the unit is still held
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rd_chk(rows[i].ra, rows[i].exp);
		end
		// Received words are ignored while the pins are deselected
		u_peer.rx_word(8'h11, 3'h2, 1'b0);
		rd_chk(ADDR_STAT, st_base);
		wr(ADDR_PFC, 24'h000001);
		check(24'({unit_hold, unit_run}), 24'h1);
		// Parity error word, then the packed read clears the flags
		u_peer.rx_word(8'h3c, 3'h2, 1'b0);
		rd_chk(ADDR_STAT, st_base | (24'h1 << ST_PARITY) | (24'h1 << ST_RXFULL));
		rd_chk(ADDR_DHI, 24'h3c0000);
		rd_chk(ADDR_STAT, st_base);
		// Load beside a data read: old byte is read, the full flag stays set
		fork
			u_peer.rx_word(8'h5b, 3'h0, 1'b0);
			rd_chk(ADDR_DLO, 24'h00003c);
		join
		rd_chk(ADDR_STAT, st_base | (24'h1 << ST_RXFULL));
		rd_chk(ADDR_DLO, 24'h00005b);
		// Address-marked transmit, then a middle-lane data byte
		wr(ADDR_TXA, 24'h00005a);
		check(24'({tx_byte, tx_ninth, tx_holding_empty}), 24'h00016a);
		rd_chk(ADDR_STAT, 24'h000001);
		repeat (20) @(negedge ref_clk);
		rd_chk(ADDR_STAT, st_base);
		wr(ADDR_DMID, 24'h00c300);
		repeat (20) @(negedge ref_clk);
		// Individual reset: flags drop, controls and data survive
		u_peer.rx_word(8'h99, 3'h1, 1'b0);
		wr(ADDR_PFC, 24'h000000);
		check(24'({unit_hold, unit_run}), 24'h2);
		rd_chk(ADDR_STAT, st_base);
		rd_chk(ADDR_IFC, 24'h00a5c3);
		rd_chk(ADDR_CLK, 24'h000fff);
		check(24'({tx_byte, tx_ninth}), 24'h000186);
		// Stop: status resets, everything else is kept
		wr(ADDR_PFC, 24'h000001);
		u_peer.rx_word(8'h42, 3'h4, 1'b1);
		stop_mode <= 1'b1;
		@(negedge ref_clk);
		check(24'({unit_hold, unit_run}), 24'h2);
		rd_chk(ADDR_STAT, st_base);
		rd_chk(ADDR_IFC, 24'h00a5c3);
		stop_mode <= 1'b0;
		@(negedge ref_clk);
		check(24'({unit_hold, unit_run}), 24'h1);
		// Interrupt use: unmasking comes last and starts the unit
		wr(ADDR_PFC, 24'h000000);
		int_used    <= 1'b1;
		int_enabled <= 1'b1;
		wr(ADDR_PFC, 24'h000002);
		check(24'({unit_hold, unit_run}), 24'h0);
		int_unmasked <= 1'b1;
		@(negedge ref_clk);
		check(24'({unit_hold, unit_run}), 24'h1);
		// Frozen clock enable: a control write is not taken
		clk_en <= 1'b0;
		wr(ADDR_IFC, 24'h001234);
		check(24'(interface_control), 24'h00a5c3);
		clk_en <= 1'b1;
		// Software reset clears controls and pins but not data
		sw_reset <= 1'b1;
		@(negedge ref_clk);
		sw_reset <= 1'b0;
		@(negedge ref_clk);
		chk_cleared();
		check(24'(tx_byte), 24'h0000c3);
		rd_chk(ADDR_DMID, 24'h004200);
		// Second hardware reset in mid-run
		wr(ADDR_IFC, 24'h00ffff);
		wr(ADDR_PFC, 24'h000004);
		hw_reset();
		chk_cleared();
		check(24'(tx_byte), 24'h0000c3);
		results();
	end
endmodule
